// ### hw/opdec_pkg.sv
// Package for the option-load and literal-return execute block.
// Assumes a 12-bit instruction word and an 8-bit working register.
`default_nettype none
package opdec_pkg;
  localparam int INSN_W = 12;
  localparam int DATA_W = 8;
  localparam int PC_W = 9;
  localparam logic [11:0] OPT_LOAD_OPCODE = 12'h002;
  localparam logic [3:0] RET_LIT_NIBBLE = 4'h8;
  localparam int NIBBLE_HI = 11;
  localparam int NIBBLE_LO = 8;
  localparam int LIT_HI = 7;
  localparam int LIT_LO = 0;
  localparam logic [7:0] WREG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam logic [8:0] PC_RESET = 9'h000;
  localparam int OPT_CYCLES = 1;
  localparam int RET_CYCLES = 2;
endpackage
`default_nettype wire

// ### hw/opdec_decode.sv
// Opcode classifier for the option-load and literal-return instructions.
// Assumes the word presented is the one in the execute slot.
`timescale 1ns/1ps
`default_nettype none
module opdec_decode (
  input wire logic [opdec_pkg::INSN_W-1:0] insn,
  output logic is_opt_load,
  output logic is_ret_lit
);
  import opdec_pkg::*;
  always_comb begin
    is_opt_load = (insn == OPT_LOAD_OPCODE);
    is_ret_lit = (insn[NIBBLE_HI:NIBBLE_LO] == RET_LIT_NIBBLE);
  end
endmodule
`default_nettype wire

// ### hw/option_load_and_literal_return.sv
// Execute stage for the option-load and literal-return instructions.
// Assumes fetch presents one word per cycle with insn_valid and honours flush.
// Behaviour
// - Option-load copies working register, one cycle
// - Literal-return loads working register with literal
// - Literal-return pops stack top into counter
// - Literal-return takes two cycles, discards fetched word
`timescale 1ns/1ps
`default_nettype none
module option_load_and_literal_return (
  input wire logic clk,
  input wire logic rst,
  input wire logic [opdec_pkg::INSN_W-1:0] insn,
  input wire logic insn_valid,
  input wire logic [opdec_pkg::DATA_W-1:0] wreg_in,
  input wire logic [opdec_pkg::PC_W-1:0] stack_top,
  output logic [opdec_pkg::DATA_W-1:0] wreg,
  output logic wreg_we,
  output logic [opdec_pkg::DATA_W-1:0] config_reg,
  output logic config_we,
  output logic [opdec_pkg::PC_W-1:0] pc_load,
  output logic pc_we,
  output logic stack_pop,
  output logic flush,
  output logic status_we
);
  import opdec_pkg::*;

  typedef enum logic {S_RUN, S_DISCARD} phase_e;

  typedef struct packed {
    phase_e phase;
    logic [DATA_W-1:0] wreg;
    logic wreg_we;
    logic [DATA_W-1:0] config_reg;
    logic config_we;
    logic [PC_W-1:0] pc_load;
    logic pc_we;
    logic stack_pop;
    logic flush;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic is_opt_load;
  logic is_ret_lit;

  opdec_decode u_dec (
    .insn(insn),
    .is_opt_load(is_opt_load),
    .is_ret_lit(is_ret_lit)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.wreg_we = 1'b0;
    st_nxt.config_we = 1'b0;
    st_nxt.pc_we = 1'b0;
    st_nxt.stack_pop = 1'b0;
    st_nxt.flush = 1'b0;
    unique case (st_r.phase)
      S_RUN: begin
        if (insn_valid && is_opt_load) begin
          st_nxt.config_reg = wreg_in;
          st_nxt.config_we = 1'b1;
        end else if (insn_valid && is_ret_lit) begin
          st_nxt.wreg = insn[LIT_HI:LIT_LO];
          st_nxt.wreg_we = 1'b1;
          st_nxt.pc_load = stack_top;
          st_nxt.pc_we = 1'b1;
          st_nxt.stack_pop = 1'b1;
          st_nxt.flush = 1'b1;
          st_nxt.phase = S_DISCARD;
        end
      end
      S_DISCARD: begin
        // Second cycle: the prefetched word is dropped, never executed
        st_nxt.phase = S_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.phase <= S_RUN;
      st_r.wreg <= WREG_RESET;
      st_r.wreg_we <= 1'b0;
      st_r.config_reg <= CONFIG_RESET;
      st_r.config_we <= 1'b0;
      st_r.pc_load <= PC_RESET;
      st_r.pc_we <= 1'b0;
      st_r.stack_pop <= 1'b0;
      st_r.flush <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wreg = st_r.wreg;
  assign wreg_we = st_r.wreg_we;
  assign config_reg = st_r.config_reg;
  assign config_we = st_r.config_we;
  assign pc_load = st_r.pc_load;
  assign pc_we = st_r.pc_we;
  assign stack_pop = st_r.stack_pop;
  assign flush = st_r.flush;
  // Tied low: these instructions must never disturb the flags
  assign status_we = 1'b0;
endmodule
`default_nettype wire

// ### testbench/olr_monitor.sv
// Checker bound to the block top
`timescale 1ns/1ps
`default_nettype none
module olr_mon(
  input wire logic clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic flush,
  input wire logic pc_we,
  input wire logic wreg_we,
  input wire logic config_we,
  input wire logic stack_pop,
  input wire logic status_we,
  input wire logic [11:0] insn,
  input wire logic [7:0] wreg_in,
  input wire logic [7:0] wreg,
  input wire logic [7:0] config_reg,
  input wire logic [8:0] stack_top,
  input wire logic [8:0] pc_load
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// Flush marks the discard cycle, so a word shown then is never taken
wire g=insn_valid&&!flush;
wire r=g&&insn[11:8]==4'h8;
opt_load_a: assert property (g&&insn==12'h002 |=> config_we&&config_reg==$past(wreg_in)) else $error("load");
ret_lit_a: assert property (r |=> wreg_we&&{4'h8,wreg}==$past(insn)) else $error("lit");
ret_pop_a: assert property (r |=> pc_we&&stack_pop&&pc_load==$past(stack_top)) else $error("pop");
ret_skip_a: assert property (r |=> flush ##1 !pc_we) else $error("skip");
no_status_a: assert property (!status_we) else $error("flag");
cover property (r ##2 r);
cover property (g&&insn==12'h002);
cover property (r ##1 insn_valid);
endmodule
bind option_load_and_literal_return olr_mon m_u(
  .clk(clk),
  .rst(rst),
  .insn_valid(insn_valid),
  .flush(flush),
  .pc_we(pc_we),
  .wreg_we(wreg_we),
  .config_we(config_we),
  .stack_pop(stack_pop),
  .status_we(status_we),
  .insn(insn),
  .wreg_in(wreg_in),
  .wreg(wreg),
  .config_reg(config_reg),
  .stack_top(stack_top),
  .pc_load(pc_load)
);
`default_nettype wire

// ### testbench/fetch_model.sv
// Fetch side: random words with stalls
`timescale 1ns/1ps
`default_nettype none
module fetch_model(
  input wire logic clk,
  output logic [11:0] insn,
  output logic insn_valid,
  output logic [7:0] wreg_in,
  output logic [8:0] stack_top
);
int seed=91994,v;
initial insn_valid=0;
always @(posedge clk) begin
#1 v=$random(seed);
insn=v[3:2]==0?12'h002:v[3:2]==1?{4'h8,v[11:4]}:v[15:4];
{insn_valid,wreg_in,stack_top}={|v[1:0],v[31:15]};
end
endmodule
`default_nettype wire

// ### testbench/option_load_and_literal_return_tb_top.sv
// Bench top; model kept beside the block
`timescale 1ns/1ps
`default_nettype none
module option_load_and_literal_return_tb_top;
logic clk=0,rst=1,insn_valid,wreg_we,config_we,pc_we,stack_pop,flush,status_we,o,k,d=0;
logic [11:0] insn;
logic [7:0] wreg_in,wreg,config_reg,ec=8'hFF,ew=0;
logic [8:0] stack_top,pc_load,ep=0;
int bad_count=0,total_checks=0,n=0;
always #12.5 clk=~clk;
fetch_model f_u(
  .clk(clk),
  .insn(insn),
  .insn_valid(insn_valid),
  .wreg_in(wreg_in),
  .stack_top(stack_top)
);
option_load_and_literal_return dut_u(
  .clk(clk),
  .rst(rst),
  .insn(insn),
  .insn_valid(insn_valid),
  .wreg_in(wreg_in),
  .stack_top(stack_top),
  .wreg(wreg),
  .wreg_we(wreg_we),
  .config_reg(config_reg),
  .config_we(config_we),
  .pc_load(pc_load),
  .pc_we(pc_we),
  .stack_pop(stack_pop),
  .flush(flush),
  .status_we(status_we)
);
task chk(string t,logic [31:0] s,e);
total_checks++;
if (s!==e) $display("FAIL %s expected %h seen %h",t,e,s);
bad_count+=s!==e;
endtask
task finish_test;
if (bad_count==0&&total_checks>0) $display("ALL CHECKS OK");
else $display("CHECKS NOT OK");
$finish;
endtask
always @(posedge clk) if (++n>2100) begin bad_count++; finish_test; end
initial begin
repeat (10) @(posedge clk);
#1 rst=0;
for (int p=0;p<2;p++) begin
repeat (1000) begin
@(posedge clk);
o=insn_valid&&!d&&insn==12'h002;
k=insn_valid&&!d&&insn[11:8]==4'h8;
if (o) ec=wreg_in;
if (k) {ew,ep}={insn[7:0],stack_top};
d=k;
#2;
chk("config",{config_we,config_reg},{o,ec});
chk("return",{wreg_we,wreg,pc_we,stack_pop,pc_load,flush},{k,ew,k,k,ep,k});
chk("status",status_we,0);
end
if (p==0) begin
// Mid-run reset lands mid-cycle; a pending discard must be dropped with it
rst=1;
{ec,ew,ep,d}={8'hFF,8'h00,9'h000,1'b0};
#1;
chk("reset",{config_we,config_reg,wreg_we,wreg,pc_we,stack_pop,pc_load,flush},{1'b0,ec,1'b0,ew,2'b00,ep,1'b0});
repeat (3) @(posedge clk);
#1 rst=0;
end
end
finish_test;
end
endmodule
`default_nettype wire
